//--- core/tfi_cond_latch.sv
// Latched two-bit transmit FIFO condition code
module tfi_cond_latch (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire tfi_pkg::tfi_evt_t evt_i,
    input  wire logic             clear_i,
    output logic [1:0]            code_o
);

    logic [1:0] code_r;
    logic [1:0] code_nxt;
    logic       set;
    logic [1:0] new_code;

    // Underflow while end of message is flagged is a normal end, not a fault
    wire uflow = evt_i.underflow & ~evt_i.end_of_message_flag;

    assign set = uflow | evt_i.overflow | evt_i.below_half;
    assign new_code = uflow             ? tfi_pkg::COND_UNDERFLOW :
                      evt_i.overflow    ? tfi_pkg::COND_OVERFLOW  :
                                          tfi_pkg::COND_BELOW;
    // Both bits load together; 00 arises only from a clear or from reset
    assign code_nxt = set     ? new_code :
                      clear_i ? tfi_pkg::COND_NORMAL :
                                code_r;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            code_r <= tfi_pkg::COND_RESET;
        else
            code_r <= code_nxt;
    end

    assign code_o = code_r;

endmodule // tfi_cond_latch

//--- core/tfi_level_events.sv
// Fill-level edge detection for the transmit FIFO
module tfi_level_events #(
    parameter int DEPTH = 128,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic [CW-1:0] fifo_count_i,
    output logic               below_half_rise_o,
    output logic               half_reached_o
);

    localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);

    wire below_now = fifo_count_i < HALF;
    wire above_now = fifo_count_i > HALF;
    wire at_now    = fifo_count_i == HALF;

    logic below_r;
    logic above_r;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            // A FIFO comes out of reset empty; no false entry into the low region
            below_r <= 1'b1;
            above_r <= 1'b0;
        end
        else
        begin
            below_r <= below_now;
            above_r <= above_now;
        end
    end

    // Only the entry into the low region is an event, not the level
    assign below_half_rise_o = below_now & ~below_r;
    assign half_reached_o    = above_r & at_now;

endmodule // tfi_level_events

//--- core/tfi_pkg.sv
// Package for the transmit link FIFO interrupt status block
package tfi_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_STATUS  = 6'h2c;
    localparam logic [5:0] IDX_RSVD    = 6'h2d;
    localparam logic [5:0] IDX_MASK    = 6'h35;
    localparam logic [5:0] IDX_CONTROL = 6'h38;
    localparam logic [5:0] IDX_CLEAR   = 6'h39;

    // Field positions in status, mask and clear registers
    localparam int SVC_BIT     = 0;
    localparam int COND_LO_BIT = 1;
    localparam int COND_HI_BIT = 2;
    localparam int STAT_W      = 3;

    // Field position in the control register
    localparam int CAUSE_SEL_BIT = 0;

    // Values after reset, and the two service cause values
    localparam logic [1:0]        COND_RESET    = 2'h0;
    localparam logic              SVC_RESET     = 1'b0;
    localparam logic [STAT_W-1:0] MASK_RESET    = 3'h0;
    localparam logic              CAUSE_RESET   = 1'b0;
    localparam logic              CAUSE_MSG     = 1'b0;
    localparam logic              CAUSE_HALF    = 1'b1;

    // Bus answer latency in cycles after the request is first seen
    localparam int BUS_WAIT_CYCLES = 1;

    // FIFO condition codes
    typedef enum logic [1:0] {
        COND_NORMAL    = 2'b00,
        COND_BELOW     = 2'b01,
        COND_OVERFLOW  = 2'b10,
        COND_UNDERFLOW = 2'b11
    } tfi_cond_t;

    // FIFO events seen in one cycle
    typedef struct packed {
        logic below_half;
        logic overflow;
        logic underflow;
        logic end_of_message_flag;
    } tfi_evt_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } tfi_avreq_t;

endpackage

//--- core/tfi_tx_irq_status.sv
// Transmit link FIFO interrupt status with Avalon-MM register access
//
// The implementer's own choice: the Avalon-MM slave port.
module tfi_tx_irq_status #(
    parameter int DEPTH = 128,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic [7:0]    avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    input  wire logic [3:0]    avs_byteenable_i,
    output logic [31:0]        avs_readdata_o,
    output logic               avs_waitrequest_o,
    input  wire logic [CW-1:0] fifo_count_i,
    input  wire logic          fifo_overflow_i,
    input  wire logic          fifo_underflow_i,
    input  wire logic          end_of_message_flag_i,
    input  wire logic          message_done_i,
    output logic [1:0]         tx_fifo_cond_o,
    output logic               tx_service_request_o,
    output logic               irq_o
);

    tfi_pkg::tfi_avreq_t req;
    tfi_pkg::tfi_evt_t   evt;

    logic                        ack_r;
    logic                        ack_nxt;
    logic [31:0]                 rdata_r;
    logic [31:0]                 rdata_nxt;
    logic [tfi_pkg::STAT_W-1:0]  mask_r;
    logic [tfi_pkg::STAT_W-1:0]  mask_nxt;
    logic                        cause_r;
    logic                        cause_nxt;
    logic                        svc_r;
    logic                        svc_nxt;
    logic [1:0]                  code;
    logic                        below_rise;
    logic                        half_reached;

    assign req.address    = avs_address_i;
    assign req.read       = avs_read_i;
    assign req.write      = avs_write_i;
    assign req.writedata  = avs_writedata_i;
    assign req.byteenable = avs_byteenable_i;

    // Bus handshake: one wait cycle, answer in the second cycle
    wire       pending = req.read | req.write;
    wire       done    = pending & ack_r;
    wire [5:0] idx     = req.address[7:2];
    wire       lane0   = req.byteenable[0];

    wire hit_status  = idx == tfi_pkg::IDX_STATUS;
    wire hit_mask    = idx == tfi_pkg::IDX_MASK;
    wire hit_control = idx == tfi_pkg::IDX_CONTROL;
    wire hit_clear   = idx == tfi_pkg::IDX_CLEAR;

    wire wr_done = done & req.write & lane0;
    wire rd_done = done & req.read;

    // Read side effect lands at the edge where the master takes the data
    wire read_clear = rd_done & hit_status;
    wire [tfi_pkg::STAT_W-1:0] wclr = (wr_done & hit_clear) ?
                                      req.writedata[tfi_pkg::STAT_W-1:0] :
                                      {tfi_pkg::STAT_W{1'b0}};

    wire [tfi_pkg::STAT_W-1:0] status = {code, svc_r};

    // Only what the master was shown is cleared; an event landing in the
    // wait cycle survives the read and is reported by the next one
    wire [1:0] seen_code     = rdata_r[tfi_pkg::COND_HI_BIT:tfi_pkg::COND_LO_BIT];
    wire       cond_read_clr = read_clear & (seen_code == code);
    wire       svc_read_clr  = read_clear & rdata_r[tfi_pkg::SVC_BIT];

    assign ack_nxt = pending & ~ack_r;
    assign avs_waitrequest_o = pending & ~ack_r;

    // Captured once when the request is taken, held through the answer
    // Reserved and unmapped locations read as zero; writes there are dropped
    assign rdata_nxt = !ack_nxt    ? rdata_r :
                       hit_status  ? {29'h0, status} :
                       hit_mask    ? {29'h0, mask_r} :
                       hit_control ? {31'h0, cause_r} :
                                     32'h0;

    assign mask_nxt  = (wr_done & hit_mask) ?
                       req.writedata[tfi_pkg::STAT_W-1:0] : mask_r;
    assign cause_nxt = (wr_done & hit_control) ?
                       req.writedata[tfi_pkg::CAUSE_SEL_BIT] : cause_r;

    tfi_level_events #(
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_level (
        .clk_i             (clk_i),
        .reset_i           (reset_i),
        .fifo_count_i      (fifo_count_i),
        .below_half_rise_o (below_rise),
        .half_reached_o    (half_reached)
    );

    assign evt.below_half = below_rise;
    assign evt.overflow   = fifo_overflow_i;
    assign evt.underflow  = fifo_underflow_i;
    assign evt.end_of_message_flag        = end_of_message_flag_i;

    // Either condition bit cleared by the clear register drops the code
    wire cond_clear = cond_read_clr | wclr[tfi_pkg::COND_LO_BIT] | wclr[tfi_pkg::COND_HI_BIT];

    tfi_cond_latch u_cond (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .evt_i   (evt),
        .clear_i (cond_clear),
        .code_o  (code)
    );

    // Service cause chosen by the control bit
    wire svc_set = (cause_r == tfi_pkg::CAUSE_HALF) ? half_reached : message_done_i;
    // A new request in the clearing cycle wins over the clear
    wire svc_clr = svc_read_clr | wclr[tfi_pkg::SVC_BIT];
    assign svc_nxt = svc_set ? 1'b1 : (svc_clr ? 1'b0 : svc_r);

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0;
            mask_r  <= tfi_pkg::MASK_RESET;
            cause_r <= tfi_pkg::CAUSE_RESET;
            svc_r   <= tfi_pkg::SVC_RESET;
        end
        else
        begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            mask_r  <= mask_nxt;
            cause_r <= cause_nxt;
            svc_r   <= svc_nxt;
        end
    end

    assign avs_readdata_o       = rdata_r;
    assign tx_fifo_cond_o       = code;
    assign tx_service_request_o = svc_r;
    // Level output, follows status and mask without further latching
    assign irq_o = |(status & mask_r);

endmodule // tfi_tx_irq_status

//--- test/tb_tfi_tx_irq_status.sv
// Testbench for the transmit link FIFO interrupt status block
module tb_tfi_tx_irq_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, reset_i = 1, rd = 0, wr = 0, end_of_message_flag = 0;
    logic [7:0] addr = 0, tgt = 8'h40, count;
    logic [31:0] wdata = 0, rdata, readdata;
    logic [2:0] op = 0;
    logic [1:0] cond;
    logic waitreq, ovf, udf, eom_w, done, svc, irq;
    int err_count = 0, cmp_count = 0, cyc = 0;
    tfi_fifo_model PM (.clk_i(clk_i), .reset_i(reset_i), .op_i(op), .target_i(tgt),
        .eom_i(end_of_message_flag), .count_o(count), .overflow_o(ovf), .underflow_o(udf), .eom_o(eom_w),
        .done_o(done));
    tfi_tx_irq_status #(.DEPTH(128), .CW(8)) DUT (.clk_i(clk_i), .reset_i(reset_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq),
        .fifo_count_i(count), .fifo_overflow_i(ovf), .fifo_underflow_i(udf),
        .end_of_message_flag_i(eom_w), .message_done_i(done), .tx_fifo_cond_o(cond),
        .tx_service_request_o(svc), .irq_o(irq));
    initial forever #4 clk_i = ~clk_i;
    task automatic results();
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard: the whole run needs about a hundred cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk_i); while (waitreq !== 1'b0);
        rdata = readdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // One-cycle event pulse, then let the load edge pass
    task automatic ev(input logic [2:0] v);
        @(posedge clk_i);
        op <= v;
        @(posedge clk_i);
        op <= 3'h0;
        @(posedge clk_i);
    endtask
    task automatic t_reset();
        bus(0, 8'hb0, 0); chk(rdata, 0);
        bus(0, 8'hd4, 0); chk(rdata, 0);
        bus(0, 8'hb4, 0); chk(rdata, 0);
        bus(0, 8'hfc, 0); chk(rdata, 0);
        chk(irq, 0);
    endtask
    task automatic t_codes();
        bus(1, 8'hd4, 7);
        ev(1); chk(cond, 2'b10); chk(irq, 1);
        bus(0, 8'hb0, 0); chk(rdata, 4);
        @(posedge clk_i); chk(cond, 0); chk(irq, 0);
        end_of_message_flag <= 1;
        ev(2); chk(cond, 0);
        end_of_message_flag <= 0;
        ev(2); chk(cond, 2'b11);
        ev(1); chk(cond, 2'b10);
        bus(0, 8'hb0, 0); chk(rdata, 4);
        tgt <= 8'h3f;
        repeat (4) @(posedge clk_i);
        chk(cond, 2'b01);
        bus(0, 8'hb0, 0); chk(rdata, 2);
        tgt <= 8'h40;
        repeat (4) @(posedge clk_i);
        chk(cond, 0);
        ev(1); chk(cond, 2'b10);
        bus(1, 8'he4, 32'h4);
        @(posedge clk_i); chk(cond, 0);
    endtask
    task automatic t_svc();
        ev(3); chk(svc, 1);
        bus(1, 8'he4, 1);
        @(posedge clk_i); chk(svc, 0);
        bus(1, 8'he0, 1);
        ev(3); chk(svc, 0);
        tgt <= 8'h41;
        repeat (4) @(posedge clk_i);
        tgt <= 8'h40;
        repeat (4) @(posedge clk_i);
        chk(svc, 1); chk(irq, 1);
        bus(1, 8'hd4, 0);
        @(posedge clk_i); chk(irq, 0);
        bus(0, 8'hb0, 0); chk(rdata, 1);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_codes();
        t_svc();
        results();
    end
endmodule // tb_tfi_tx_irq_status

//--- test/tfi_fifo_model.sv
// Stand-in for the transmit FIFO that feeds events to the status block
module tfi_fifo_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] op_i,
    input  wire logic [7:0] target_i,
    input  wire logic       eom_i,
    output logic [7:0]      count_o,
    output logic            overflow_o,
    output logic            underflow_o,
    output logic            eom_o,
    output logic            done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Fill moves one word a cycle, so level edges are seen one at a time
    always_ff @(posedge clk_i or posedge reset_i)
        if (reset_i)
            count_o <= 8'h40;
        else if (count_o != target_i)
            count_o <= (count_o < target_i) ? count_o + 8'h01 : count_o - 8'h01;
    assign overflow_o  = (op_i == 3'h1);
    assign underflow_o = (op_i == 3'h2);
    assign done_o      = (op_i == 3'h3);
    assign eom_o       = eom_i;
endmodule // tfi_fifo_model

//--- test/tfi_tx_irq_status_sva.sv
// Assertions for the transmit link FIFO interrupt status block
module tfi_tx_irq_status_sva #(
    parameter int DEPTH = 128,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    input wire logic          clk_i,
    input wire logic          reset_i,
    input wire logic          avs_read_i,
    input wire logic          avs_write_i,
    input wire logic          avs_waitrequest_o,
    input wire logic [CW-1:0] fifo_count_i,
    input wire logic          fifo_overflow_i,
    input wire logic          fifo_underflow_i,
    input wire logic          end_of_message_flag_i,
    input wire logic          message_done_i,
    input wire logic [1:0]    tx_fifo_cond_o,
    input wire logic          tx_service_request_o,
    input wire logic          irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = DEPTH / 2;
    logic bus_done;
    logic quiet;
    assign bus_done = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign quiet = ~(fifo_overflow_i | fifo_underflow_i | avs_read_i | avs_write_i);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_irq; irq_o |-> (tx_fifo_cond_o != 2'h0) || tx_service_request_o; endproperty
    a_irq: assert property (p_irq) else $error("irq with no status");
    property p_zero; $past(tx_fifo_cond_o) != 2'h0 && tx_fifo_cond_o == 2'h0 |-> $past(bus_done);
    endproperty
    a_zero: assert property (p_zero) else $error("code zeroed without access");
    property p_hold; quiet && $stable(fifo_count_i) |=> $stable(tx_fifo_cond_o);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved without cause");
    property p_ovf; fifo_overflow_i && !fifo_underflow_i |=> tx_fifo_cond_o == 2'b10; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow code wrong");
    property p_udf; fifo_underflow_i && !end_of_message_flag_i |=> tx_fifo_cond_o == 2'b11;
    endproperty
    a_udf: assert property (p_udf) else $error("underflow code wrong");
    property p_below;
        $past(fifo_count_i) >= H && fifo_count_i < H && !fifo_overflow_i && !fifo_underflow_i
        |-> ##[1:2] tx_fifo_cond_o == 2'b01;
    endproperty
    a_below: assert property (p_below) else $error("below half code wrong");
    property p_svc;
        $rose(tx_service_request_o) |->
        $past(message_done_i) || $past(fifo_count_i) != $past(fifo_count_i, 3);
    endproperty
    a_svc: assert property (p_svc) else $error("service request without cause");
    property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    c_irq: cover property ($rose(irq_o));
    c_udf: cover property (tx_fifo_cond_o == 2'b11);
    c_svc: cover property ($rose(tx_service_request_o));
endmodule // tfi_tx_irq_status_sva

bind tfi_tx_irq_status tfi_tx_irq_status_sva #(.DEPTH(DEPTH), .CW(CW)) u_sva (.*);
